// ===== rtl/ddr_drive_strength_regs.v
// drive strength register bank for the ddr pad groups, ahb-lite slave
// assumes a single master, word transfers, and pads that sample levels
`timescale 1ns/1ps
`include "ddr_strength_consts.vh"

// What this block does
// RULE1: command group strength in bits 6:4 of data/command register, 111 reserved.
// RULE2: data and strobe strength in bits 2:0 of data/command register.
// RULE3: clock-enable x16 strength in bits 6:4, resets to 0.75x code 000.
// RULE4: clock-enable x8 strength in bits 2:0 of its register.
// RULE5: chip-select x16 strength in bits 6:4 of its register.
// RULE6: chip-select x8 strength in bits 2:0 of its register.
// RULE7: clock pair x16 strength in bits 6:4 of its register.
// RULE8: clock pair x8 strength in bits 2:0 of its register.
// RULE9: true and complement clock of a pair get the same strength.
// RULE10: receive-enable-out strength in bits 2:0; bits 7:3 reserved.
// RULE11: per signal, width register chooses x8 or x16 setting.
// RULE12: all five strength registers reset to 00h, every field 0.75x.
// RULE13: width bit 0 means x16 or empty module, 1 means x8.
// RULE14: reserved bits 7 and 3 read zero and ignore writes.
module ddr_drive_strength_regs (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // ahb-lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata_ff,
    output reg hreadyout_ff,
    output reg hresp_ff,
    // strength levels to the pads
    output reg [2:0] data_strobe_strength_ff,
    output reg [2:0] command_strength_ff,
    output reg [11:0] clock_enable_strength_ff,
    output reg [11:0] chip_select_strength_ff,
    output reg [17:0] clock_true_strength_ff,
    output reg [17:0] clock_comp_strength_ff,
    output reg [2:0] receive_enable_out_pin_strength_ff
);

    // byte address of a register index
    function [31:0] reg_addr;
        input [7:0] idx;
        begin
            reg_addr = {22'h000000, idx, 2'h0};
        end
    endfunction

    // true when a field holds the reserved multiplier code
    function is_reserved_code;
        input [2:0] code;
        begin
            is_reserved_code = (code == `CODE_RESERVED);
        end
    endfunction

    // register contents
    wire [7:0] data_command_drive_strength;
    wire [7:0] clock_enable_drive_strength;
    wire [7:0] chip_select_drive_strength;
    wire [7:0] clock_pair_drive_strength;
    wire [7:0] receive_enable_out_strength;
    reg [1:0] module_device_width_ff;
    reg [1:0] nxt_module_device_width;

    // bus phase tracking
    reg wr_pending_ff;
    reg [31:0] wr_addr_ff;
    reg rd_pending_ff;
    reg [31:0] rd_addr_ff;
    reg nxt_wr_pending;
    reg [31:0] nxt_wr_addr;
    reg nxt_rd_pending;
    reg [31:0] nxt_rd_addr;
    reg nxt_hreadyout;
    reg [31:0] nxt_hrdata;
    reg [31:0] readback;
    reg [8:0] reserved_code_seen;

    // write strobes, one per register
    wire wr_data_command;
    wire wr_clock_enable;
    wire wr_chip_select;
    wire wr_clock_pair;
    wire wr_receive_enable;
    wire wr_module_width;
    wire addr_phase;

    // per-signal selected strengths
    wire [11:0] cke_sel;
    wire [11:0] cs_sel;
    wire [17:0] clk_sel;

    // an address phase is taken only when the bus is ready
    assign addr_phase = hsel && hready && (htrans == `HTRANS_NONSEQ);

    // a write lands in the data phase, after the address was taken
    assign wr_data_command = wr_pending_ff && (wr_addr_ff == reg_addr(`IDX_DATA_COMMAND));
    assign wr_clock_enable = wr_pending_ff && (wr_addr_ff == reg_addr(`IDX_CLOCK_ENABLE));
    assign wr_chip_select = wr_pending_ff && (wr_addr_ff == reg_addr(`IDX_CHIP_SELECT));
    assign wr_clock_pair = wr_pending_ff && (wr_addr_ff == reg_addr(`IDX_CLOCK_PAIR));
    assign wr_receive_enable = wr_pending_ff && (wr_addr_ff == reg_addr(`IDX_RECEIVE_ENABLE));
    assign wr_module_width = wr_pending_ff && (wr_addr_ff == reg_addr(`IDX_MODULE_WIDTH));

    // RULE1 cmd and data fields
    // RULE2 share one register
    // RULE12 reset to zero
    // RULE14 reserved bits masked
    pad_strength_reg #(
        .WMASK(`STRENGTH_WMASK)
    ) u_data_command (
        .hclk(hclk),
        .hresetn(hresetn),
        .wr_en(wr_data_command),
        .wr_data(hwdata[7:0]),
        .value_ff(data_command_drive_strength)
    );

    // RULE3 cke x16 field
    // RULE4 cke x8 field
    pad_strength_reg #(
        .WMASK(`STRENGTH_WMASK)
    ) u_clock_enable (
        .hclk(hclk),
        .hresetn(hresetn),
        .wr_en(wr_clock_enable),
        .wr_data(hwdata[7:0]),
        .value_ff(clock_enable_drive_strength)
    );

    // RULE5 cs x16 field
    // RULE6 cs x8 field
    pad_strength_reg #(
        .WMASK(`STRENGTH_WMASK)
    ) u_chip_select (
        .hclk(hclk),
        .hresetn(hresetn),
        .wr_en(wr_chip_select),
        .wr_data(hwdata[7:0]),
        .value_ff(chip_select_drive_strength)
    );

    // RULE7 clock x16 field
    // RULE8 clock x8 field
    pad_strength_reg #(
        .WMASK(`STRENGTH_WMASK)
    ) u_clock_pair (
        .hclk(hclk),
        .hresetn(hresetn),
        .wr_en(wr_clock_pair),
        .wr_data(hwdata[7:0]),
        .value_ff(clock_pair_drive_strength)
    );

    // RULE10 receive enable field
    pad_strength_reg #(
        .WMASK(`RCVEN_WMASK)
    ) u_receive_enable (
        .hclk(hclk),
        .hresetn(hresetn),
        .wr_en(wr_receive_enable),
        .wr_data(hwdata[7:0]),
        .value_ff(receive_enable_out_strength)
    );

    // width register, one bit per module, low two bits only
    always @* begin
        nxt_module_device_width = module_device_width_ff;
        if (wr_module_width) begin
            nxt_module_device_width = hwdata[1:0] & `WIDTH_WMASK;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            module_device_width_ff <= `WIDTH_RST;
        end else begin
            module_device_width_ff <= nxt_module_device_width;
        end
    end

    // RULE11 per-row width pick
    // RULE13 bit 0 is x16
    // rows 0-1 follow module 0, rows 2-3 follow module 1
    genvar row;
    generate
        for (row = 0; row < `ROW_COUNT; row = row + 1) begin : g_row
            strength_select u_cke_sel (
                .x16_strength(clock_enable_drive_strength[`HI_MSB:`HI_LSB]),
                .x8_strength(clock_enable_drive_strength[`LO_MSB:`LO_LSB]),
                .width_bit(module_device_width_ff[row / `ROWS_PER_MODULE]),
                .strength(cke_sel[row * `FIELD_BITS +: `FIELD_BITS])
            );
            strength_select u_cs_sel (
                .x16_strength(chip_select_drive_strength[`HI_MSB:`HI_LSB]),
                .x8_strength(chip_select_drive_strength[`LO_MSB:`LO_LSB]),
                .width_bit(module_device_width_ff[row / `ROWS_PER_MODULE]),
                .strength(cs_sel[row * `FIELD_BITS +: `FIELD_BITS])
            );
        end
    endgenerate

    // RULE11 per-pair width pick
    // pairs 0-2 go to module 0, pairs 3-5 to module 1
    genvar pair;
    generate
        for (pair = 0; pair < `CLK_PAIR_COUNT; pair = pair + 1) begin : g_pair
            strength_select u_clk_sel (
                .x16_strength(clock_pair_drive_strength[`HI_MSB:`HI_LSB]),
                .x8_strength(clock_pair_drive_strength[`LO_MSB:`LO_LSB]),
                .width_bit(module_device_width_ff[pair / `PAIRS_PER_MODULE]),
                .strength(clk_sel[pair * `FIELD_BITS +: `FIELD_BITS])
            );
        end
    endgenerate

    // pad levels are registered so no decode glitch reaches the analog trim
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            data_strobe_strength_ff <= `STRENGTH_OUT_RST;
            command_strength_ff <= `STRENGTH_OUT_RST;
            clock_enable_strength_ff <= {`ROW_COUNT{`STRENGTH_OUT_RST}};
            chip_select_strength_ff <= {`ROW_COUNT{`STRENGTH_OUT_RST}};
            clock_true_strength_ff <= {`CLK_PAIR_COUNT{`STRENGTH_OUT_RST}};
            clock_comp_strength_ff <= {`CLK_PAIR_COUNT{`STRENGTH_OUT_RST}};
            receive_enable_out_pin_strength_ff <= `STRENGTH_OUT_RST;
        end else begin
            // RULE1 command group drive
            command_strength_ff <= data_command_drive_strength[`HI_MSB:`HI_LSB];
            // RULE2 data strobe drive
            data_strobe_strength_ff <= data_command_drive_strength[`LO_MSB:`LO_LSB];
            clock_enable_strength_ff <= cke_sel;
            chip_select_strength_ff <= cs_sel;
            // RULE9 both clock legs
            clock_true_strength_ff <= clk_sel;
            clock_comp_strength_ff <= clk_sel;
            // RULE10 receive enable drive
            receive_enable_out_pin_strength_ff <= receive_enable_out_strength[`LO_MSB:`LO_LSB];
        end
    end

    // live view of fields holding the reserved code; the pad result is undefined
    always @* begin
        reserved_code_seen[0] = is_reserved_code(data_command_drive_strength[`LO_MSB:`LO_LSB]);
        reserved_code_seen[1] = is_reserved_code(data_command_drive_strength[`HI_MSB:`HI_LSB]);
        reserved_code_seen[2] = is_reserved_code(clock_enable_drive_strength[`LO_MSB:`LO_LSB]);
        reserved_code_seen[3] = is_reserved_code(clock_enable_drive_strength[`HI_MSB:`HI_LSB]);
        reserved_code_seen[4] = is_reserved_code(chip_select_drive_strength[`LO_MSB:`LO_LSB]);
        reserved_code_seen[5] = is_reserved_code(chip_select_drive_strength[`HI_MSB:`HI_LSB]);
        reserved_code_seen[6] = is_reserved_code(clock_pair_drive_strength[`LO_MSB:`LO_LSB]);
        reserved_code_seen[7] = is_reserved_code(clock_pair_drive_strength[`HI_MSB:`HI_LSB]);
        reserved_code_seen[8] = is_reserved_code(receive_enable_out_strength[`LO_MSB:`LO_LSB]);
    end

    // RULE14 reserved bits read zero
    // unmapped words read zero too
    always @* begin
        case (rd_addr_ff)
            reg_addr(`IDX_DATA_COMMAND): readback = {24'h000000, data_command_drive_strength};
            reg_addr(`IDX_CLOCK_ENABLE): readback = {24'h000000, clock_enable_drive_strength};
            reg_addr(`IDX_CHIP_SELECT): readback = {24'h000000, chip_select_drive_strength};
            reg_addr(`IDX_CLOCK_PAIR): readback = {24'h000000, clock_pair_drive_strength};
            reg_addr(`IDX_RECEIVE_ENABLE): readback = {24'h000000, receive_enable_out_strength};
            reg_addr(`IDX_MODULE_WIDTH): readback = {30'h00000000, module_device_width_ff};
            reg_addr(`IDX_RESERVED_CODE): readback = {23'h000000, reserved_code_seen};
            default: readback = `RDATA_ZERO;
        endcase
    end

    // bus phase control: writes take no wait, reads take one wait state
    // the wait lets a read see a write finished in the cycle before
    always @* begin
        nxt_wr_pending = 1'b0;
        nxt_wr_addr = wr_addr_ff;
        nxt_rd_pending = 1'b0;
        nxt_rd_addr = rd_addr_ff;
        nxt_hreadyout = 1'b1;
        nxt_hrdata = hrdata_ff;
        if (rd_pending_ff) begin
            nxt_hrdata = readback;
        end else if (addr_phase) begin
            if (hwrite) begin
                // narrow writes are dropped; only whole words land
                nxt_wr_pending = (hsize == `HSIZE_WORD);
                nxt_wr_addr = haddr;
            end else begin
                nxt_rd_pending = 1'b1;
                nxt_rd_addr = haddr;
                nxt_hreadyout = 1'b0;
            end
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pending_ff <= 1'b0;
            wr_addr_ff <= `RDATA_ZERO;
            rd_pending_ff <= 1'b0;
            rd_addr_ff <= `RDATA_ZERO;
            hreadyout_ff <= 1'b1;
            hrdata_ff <= `RDATA_ZERO;
            hresp_ff <= `HRESP_OKAY;
        end else begin
            wr_pending_ff <= nxt_wr_pending;
            wr_addr_ff <= nxt_wr_addr;
            rd_pending_ff <= nxt_rd_pending;
            rd_addr_ff <= nxt_rd_addr;
            hreadyout_ff <= nxt_hreadyout;
            hrdata_ff <= nxt_hrdata;
            hresp_ff <= `HRESP_OKAY;  // every answer is okay
        end
    end

endmodule

// ===== rtl/ddr_strength_consts.vh
// constants for the ddr pad drive strength register bank
// assumes a 32-bit ahb-lite bus, one register per aligned word
`ifndef DDR_STRENGTH_CONSTS_VH
`define DDR_STRENGTH_CONSTS_VH

// register indices; byte address is four times the index
`define IDX_DATA_COMMAND 8'h30
`define IDX_CLOCK_ENABLE 8'h31
`define IDX_CHIP_SELECT 8'h32
`define IDX_CLOCK_PAIR 8'h33
`define IDX_RECEIVE_ENABLE 8'h34
`define IDX_MODULE_WIDTH 8'h4D
`define IDX_RESERVED_CODE 8'h4E

// field positions inside an 8-bit strength register
`define FIELD_BITS 3
`define HI_MSB 6
`define HI_LSB 4
`define LO_MSB 2
`define LO_LSB 0

// writable bit masks; reserved bits read zero
`define STRENGTH_WMASK 8'h77
`define RCVEN_WMASK 8'h07
`define WIDTH_WMASK 2'h3

// reset values
`define STRENGTH_RST 8'h00
`define WIDTH_RST 2'h0
`define STRENGTH_OUT_RST 3'h0

// encodings
`define CODE_RESERVED 3'h7
`define WIDTH_X8 1'b1
`define HTRANS_NONSEQ 2'h2
`define HSIZE_WORD 3'h2
`define HRESP_OKAY 1'b0
`define RDATA_ZERO 32'h00000000

// pad group sizes
`define ROW_COUNT 4
`define CLK_PAIR_COUNT 6
`define ROWS_PER_MODULE 2
`define PAIRS_PER_MODULE 3

`endif

// ===== rtl/pad_strength_reg.v
// one 8-bit drive strength register with reserved bits masked
// assumes the write strobe is a single-cycle pulse in the hclk domain
`timescale 1ns/1ps
`include "ddr_strength_consts.vh"

module pad_strength_reg #(
    parameter [7:0] WMASK = `STRENGTH_WMASK
) (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // write side
    input wire wr_en,
    input wire [7:0] wr_data,
    // stored value
    output reg [7:0] value_ff
);

    // reserved bits never take a write, so they always read zero
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            value_ff <= `STRENGTH_RST;
        end else if (wr_en) begin
            value_ff <= wr_data & WMASK;
        end
    end

endmodule

// ===== rtl/strength_select.v
// picks the x8 or x16 strength setting for one pad signal
// assumes the width bit comes from the module width register
`timescale 1ns/1ps
`include "ddr_strength_consts.vh"

module strength_select (
    // the two programmed settings
    input wire [2:0] x16_strength,
    input wire [2:0] x8_strength,
    // width of the devices behind this signal
    input wire width_bit,
    // chosen setting
    output wire [2:0] strength
);

    // width bit 1 means x8 parts; 0 means x16 parts or an empty module
    assign strength = (width_bit == `WIDTH_X8) ? x8_strength : x16_strength;

endmodule

// ===== verification/ddr_strength_monitor.sv
// port checker for the drive strength bank
// assumes hready is tied to hreadyout_ff by the bench
`timescale 1ns/1ps

module ddr_strength_monitor (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // bus
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hrdata_ff,
    input wire hreadyout_ff,
    input wire hresp_ff,
    // pads
    input wire [2:0] data_strobe_strength_ff,
    input wire [2:0] command_strength_ff,
    input wire [11:0] clock_enable_strength_ff,
    input wire [11:0] chip_select_strength_ff,
    input wire [17:0] clock_true_strength_ff,
    input wire [17:0] clock_comp_strength_ff
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // accepted transfers
    wire rd_t = hsel && hready && htrans == 2'h2 && !hwrite;
    wire wr_t = hsel && hready && htrans == 2'h2 && hwrite;
    wire [11:0] ce = clock_enable_strength_ff;
    wire [11:0] cs = chip_select_strength_ff;
    wire [17:0] ck = clock_true_strength_ff;

    chk_true_comp_same: assert property (clock_comp_strength_ff == ck)
        else $error("clock complement strength differs from true");
    chk_resp_okay: assert property (hresp_ff == 1'b0)
        else $error("error response seen");
    chk_read_wait: assert property (rd_t |=> !hreadyout_ff ##1 hreadyout_ff)
        else $error("read wait state wrong");
    chk_write_nowait: assert property (wr_t |=> hreadyout_ff)
        else $error("write stalled");
    chk_single_wait: assert property (!hreadyout_ff |=> hreadyout_ff)
        else $error("wait longer than one cycle");
    // pads only move after a write two edges back
    chk_pads_hold: assert property (!wr_t [*3] |=> $stable({data_strobe_strength_ff, command_strength_ff, ce, cs, ck}))
        else $error("pad strength moved without a write");
    chk_rdata_upper: assert property (hrdata_ff[31:9] == 23'h0)
        else $error("upper read bits not zero");
    // rows of one module share a width bit, so share a setting
    chk_cke_rows: assert property (ce[2:0] == ce[5:3] && ce[8:6] == ce[11:9])
        else $error("clock enable rows of one module differ");
    chk_cs_rows: assert property (cs[2:0] == cs[5:3] && cs[8:6] == cs[11:9])
        else $error("chip select rows of one module differ");
    chk_ck_groups: assert property (ck[2:0] == ck[5:3] && ck[5:3] == ck[8:6] && ck[11:9] == ck[14:12]
        && ck[14:12] == ck[17:15])
        else $error("clock pairs of one module differ");
    // read data stands two edges after the address is taken
    chk_rsvd_bits: assert property (rd_t && haddr[31:4] == 28'h000000C
        |-> ##2 (hrdata_ff[7] == 1'b0 && hrdata_ff[3] == 1'b0))
        else $error("reserved strength bit read as one");
    chk_rcv_upper: assert property (rd_t && haddr == 32'h000000D0 |-> ##2 hrdata_ff[7:3] == 5'h00)
        else $error("receive enable reserved bits read as one");
endmodule

bind ddr_drive_strength_regs ddr_strength_monitor ddr_strength_monitor_inst (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata_ff(hrdata_ff),
    .hreadyout_ff(hreadyout_ff), .hresp_ff(hresp_ff), .data_strobe_strength_ff(data_strobe_strength_ff),
    .command_strength_ff(command_strength_ff), .clock_enable_strength_ff(clock_enable_strength_ff),
    .chip_select_strength_ff(chip_select_strength_ff), .clock_true_strength_ff(clock_true_strength_ff),
    .clock_comp_strength_ff(clock_comp_strength_ff));

// ===== verification/pad_group_model.sv
// pad-side model: the so-dimm pads sample the strength levels each clock
// assumes levels settle within one hclk cycle
`timescale 1ns/1ps

module pad_group_model (
    // clock
    input wire hclk,
    // strength levels from the bank
    input wire [2:0] data_strobe_strength_ff,
    input wire [2:0] command_strength_ff,
    input wire [11:0] clock_enable_strength_ff,
    input wire [11:0] chip_select_strength_ff,
    input wire [17:0] clock_true_strength_ff,
    input wire [17:0] clock_comp_strength_ff,
    input wire [2:0] receive_enable_out_pin_strength_ff,
    // strengths the pads actually apply
    output logic [68:0] applied_ff
);
    // pads just latch levels; no reset, as real buffers have none
    always @(posedge hclk) begin
        applied_ff <= {data_strobe_strength_ff, command_strength_ff, clock_enable_strength_ff,
            chip_select_strength_ff, clock_true_strength_ff, clock_comp_strength_ff,
            receive_enable_out_pin_strength_ff};
    end
endmodule

// ===== verification/tb.sv
// self-checking bench: ahb-lite master, register shadow, pad model
// assumes the bank answers writes at once and reads after one wait
`timescale 1ns/1ps
`include "ddr_strength_consts.vh"

module tb;
    logic hclk, hresetn, hsel, hwrite;
    logic [31:0] haddr, hwdata, rd;
    logic [1:0] htrans, wd;
    logic [2:0] hsize;
    logic [15:0] lf;
    logic [7:0] sh [5];
    wire [31:0] hrdata_ff;
    wire hreadyout_ff;
    wire [2:0] dq, cmd, rcv;
    wire [11:0] ce, cs;
    wire [17:0] ckt, ckc;
    wire [68:0] applied;
    int err_total, checks, i, n, pass;

    ddr_drive_strength_regs ddr_drive_strength_regs_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout_ff), .hrdata_ff(hrdata_ff), .hreadyout_ff(hreadyout_ff), .hresp_ff(),
        .data_strobe_strength_ff(dq), .command_strength_ff(cmd), .clock_enable_strength_ff(ce),
        .chip_select_strength_ff(cs), .clock_true_strength_ff(ckt), .clock_comp_strength_ff(ckc),
        .receive_enable_out_pin_strength_ff(rcv));
    pad_group_model pad_group_model_inst (.hclk(hclk), .data_strobe_strength_ff(dq), .command_strength_ff(cmd),
        .clock_enable_strength_ff(ce), .chip_select_strength_ff(cs), .clock_true_strength_ff(ckt),
        .clock_comp_strength_ff(ckc), .receive_enable_out_pin_strength_ff(rcv), .applied_ff(applied));

    // 10 ns clock
    always #5 hclk = ~hclk;

    function automatic [15:0] lfsr_next(input [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    // index 0..4 are the strength registers, 5 the width register, 6 the reserved-code status
    function automatic [31:0] adr(input int k);
        if (k < 5) return {22'h0, `IDX_DATA_COMMAND + k[7:0], 2'b00};
        return {22'h0, (k == 5) ? `IDX_MODULE_WIDTH : `IDX_RESERVED_CODE, 2'b00};
    endfunction

    // status flags a field holding code 111: low field at even bit, high field at odd bit
    function automatic [31:0] exp_reg(input int k);
        logic [8:0] s;
        int r;
        for (r = 0; r < 4; r++) begin
            s[2*r] = &sh[r][2:0];
            s[2*r+1] = &sh[r][6:4];
        end
        s[8] = &sh[4][2:0];
        if (k < 5) return {24'h0, sh[k]};
        if (k == 5) return {30'h0, wd};
        return {23'h0, s};
    endfunction

    // each signal takes x8 setting when its module width bit is 1
    function automatic [68:0] exp_pads();
        logic [11:0] e, c;
        logic [17:0] k;
        int r;
        for (r = 0; r < 4; r++) begin
            e[3*r+:3] = wd[r/2] ? sh[1][2:0] : sh[1][6:4];
            c[3*r+:3] = wd[r/2] ? sh[2][2:0] : sh[2][6:4];
        end
        for (r = 0; r < 6; r++) k[3*r+:3] = wd[r/3] ? sh[3][2:0] : sh[3][6:4];
        return {sh[0][2:0], sh[0][6:4], e, c, k, k, sh[4][2:0]};
    endfunction

    task automatic check(input [68:0] seen, input [68:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        if (err_total == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // one single transfer; the bench timeout bounds every wait
    task automatic xfer(input logic wr, input [31:0] a, input [31:0] d, input [2:0] sz, output [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        hsize <= sz;
        do @(posedge hclk); while (hreadyout_ff !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout_ff !== 1'b1);
        q = hrdata_ff;
    endtask

    // write, update shadow with writable bits only, read back, compare pads
    task automatic wr_chk(input int k, input [31:0] d);
        xfer(1'b1, adr(k), d, 3'h2, rd);
        if (k < 5) sh[k] = d[7:0] & ((k == 4) ? 8'h07 : 8'h77);
        else wd = d[1:0];
        xfer(1'b0, adr(k), 32'h0, 3'h2, rd);
        check(rd, exp_reg(k));
        check(applied, exp_pads());
    endtask

    initial begin
        #100000;
        err_total++;
        stop_test();
    end

    initial begin
        hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0;
        hwrite = 0; hsize = 3'h2; hwdata = 0; lf = 16'h236A;
        err_total = 0;
        checks = 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        for (pass = 0; pass < 2; pass++) begin
            for (i = 0; i < 5; i++) sh[i] = 8'h00;
            wd = 2'h0;
            for (i = 0; i < 7; i++) begin
                xfer(1'b0, adr(i), 32'h0, 3'h2, rd);
                check(rd, exp_reg(i));
            end
            check(applied, exp_pads());
            // all ones: reserved code 111 stored, reserved bits dropped
            for (i = 0; i < 6; i++) wr_chk(i, 32'hFFFFFFFF);
            // every field now holds 111; the status word is read only
            xfer(1'b1, adr(6), 32'h00000000, 3'h2, rd);
            xfer(1'b0, adr(6), 32'h0, 3'h2, rd);
            check(rd, exp_reg(6));
            for (n = 0; n < 40; n++) begin
                lf = lfsr_next(lf);
                i = lf % 6;
                lf = lfsr_next(lf);
                wr_chk(i, {16'h0, lf});
            end
            xfer(1'b0, adr(6), 32'h0, 3'h2, rd);
            check(rd, exp_reg(6));
            // byte-sized write must not land
            xfer(1'b1, adr(0), 32'h00000011, 3'h0, rd);
            xfer(1'b0, adr(0), 32'h0, 3'h2, rd);
            check(rd, exp_reg(0));
            // printed offset used as byte address is unmapped
            xfer(1'b1, 32'h00000030, 32'h00000055, 3'h2, rd);
            xfer(1'b0, 32'h00000030, 32'h0, 3'h2, rd);
            check(rd, 32'h0);
            check(applied, exp_pads());
            // reset again in mid-run
            hsel <= 1'b0;
            hresetn <= 1'b0;
            repeat (2) @(posedge hclk);
            hresetn <= 1'b1;
        end
        stop_test();
    end
endmodule
